/* File: selwake_mode_defs.vh */
/*
  Constants for the CAN transceiver mode controller: chip modes, mode field
  codes, effective transceiver modes and reset values.
  Assumes inclusion by bare name from design and verification files.
*/
`ifndef SELWAKE_MODE_DEFS_VH
`define SELWAKE_MODE_DEFS_VH

// chip modes (input chipMode)
`define CHIP_NORMAL 3'h0
`define CHIP_STOP 3'h1
`define CHIP_SLEEP 3'h2
`define CHIP_RESTART 3'h3
`define CHIP_FAILSAFE 3'h4
`define CHIP_INIT 3'h5

// mode field codes
`define FLD_OFF0 3'h0
`define FLD_WAKE 3'h1
`define FLD_RXONLY 3'h2
`define FLD_NORMAL 3'h3
`define FLD_OFF1 3'h4
`define FLD_SELWAKE 3'h5
`define FLD_RXSW 3'h6
`define FLD_NORMSW 3'h7
`define FLD_SW_BIT 2

// effective transceiver modes (output xcvrMode)
`define XM_OFF 3'h0
`define XM_WAKE 3'h1
`define XM_RXONLY 3'h2
`define XM_NORMAL 3'h3
`define XM_SELWAKE 3'h4
`define XM_RXSW 3'h5
`define XM_NORMSW 3'h6
`define XM_WOKEN 3'h7

// reset values
`define RST_FIELD 3'h0
`define RST_FLAG 1'h0

`endif

/* File: selwake_decode.v */
/*
  Combinational decode of mode field plus error flag into the effective
  transceiver mode. Assumes the caller handles woken and fail-safe states.
*/
`timescale 1ns/10ps
`default_nettype none
`include "selwake_mode_defs.vh"

module selwake_decode (
  input wire [2:0] field,
  input wire errFlag,
  input wire [2:0] chipMode,
  output reg [2:0] xm
);

  always @* begin
    xm = `XM_OFF;
    case (field)
      `FLD_OFF0, `FLD_OFF1: xm = `XM_OFF;
      `FLD_WAKE: xm = `XM_WAKE;
      `FLD_RXONLY: xm = `XM_RXONLY;
      `FLD_NORMAL: begin
        if (chipMode == `CHIP_NORMAL) begin
          xm = `XM_NORMAL;
        end else begin
          xm = `XM_WAKE;
        end
      end
      `FLD_SELWAKE: xm = errFlag ? `XM_WAKE : `XM_SELWAKE;
      `FLD_RXSW: xm = errFlag ? `XM_RXONLY : `XM_RXSW;
      `FLD_NORMSW: xm = errFlag ? `XM_NORMAL : `XM_NORMSW;
      default: xm = `XM_OFF;
    endcase
  end

endmodule // selwake_decode
`default_nettype wire

/* File: can_selective_wake_mode_control.v */
/*
  CAN transceiver mode controller with selective wake: holds the mode field,
  error, armed and config-valid flags, and derives the effective transceiver
  mode from chip mode transitions.
  Assumes chipMode, events and writes come from logic on clk; raw bus inputs
  (busRxRaw) come from outside and are synchronised here.
*/
//
// Summary of operation
// - mode field writable only in chip normal
// - field codes map to off/wake/rx/normal/selwake
// - normal with selwake: traffic plus monitoring
// - wake frame in normal: interrupt, woken mode holds rx high
// - rx-only selwake never drives the bus
// - clear error flag means selwake active
// - normal mode reads return programmed field
// - leaving normal may rewrite low field bits
// - stop keeps field; normal becomes wake
// - error set: no wake frames, top bit kept
// - sleep: 010/011 rewritten to 001
// - sleep: 101/110/111 rewritten to 101
// - sleep wake frame: restart, config-valid cleared
// - woken transceiver needs rearm by mode change
// - sleep entry rearms a woken transceiver
// - error flag set only in selwake modes
// - fail-safe forces wake capable, no selwake
`timescale 1ns/10ps
`default_nettype none
`include "selwake_mode_defs.vh"

module can_selective_wake_mode_control (
  input wire clk,
  input wire nrst,
  input wire [2:0] chipMode,
  input wire fieldWr,
  input wire [2:0] fieldWrData,
  input wire errClr,
  input wire cfgValidSet,
  input wire cfgValidClr,
  input wire cfgCheckFail,
  input wire errCntOverflow,
  input wire wakeFrame,
  input wire wakePattern,
  input wire busIdleTimeout,
  input wire busRxRaw,
  input wire txData,
  output reg [2:0] fieldRd,
  output reg selwakeErrorFlag,
  output reg selwakeArmedFlag,
  output reg selwakeConfigValid,
  output reg busSilenceFlag,
  output reg [2:0] xcvrMode,
  output reg canWakeIrq,
  output reg restartReq,
  output reg woken,
  output reg rxOut,
  output reg txOut
);

  ////////////////////////////////////////////////////////////////////////////
  function isSelwakeCode;
    input [2:0] f;
    begin
      isSelwakeCode = f[`FLD_SW_BIT] & (f[1] | f[0]);
    end
  endfunction

  reg [2:0] field_r, field_nxt;
  reg [2:0] prevChip_r;
  reg err_nxt, armed_nxt, cfg_nxt, sil_nxt, woken_nxt;
  reg rxSync1_r, rxSync2_r;
  wire [2:0] decXm;
  wire enterStop, enterSleep, enterFailsafe, inNormal, selwakeLive;

  // decode the field and flag that will stand after this edge, so the
  // registered mode matches the rewritten field on the first low-power cycle
  // instead of lagging one cycle behind it
  selwake_decode uDecode (
    .field(field_nxt),
    .errFlag(err_nxt),
    .chipMode(chipMode),
    .xm(decXm)
  );

  assign inNormal = (chipMode == `CHIP_NORMAL);
  assign enterStop = (chipMode == `CHIP_STOP) && (prevChip_r != `CHIP_STOP);
  assign enterSleep = (chipMode == `CHIP_SLEEP) &&
    (prevChip_r != `CHIP_SLEEP);
  assign enterFailsafe = (chipMode == `CHIP_FAILSAFE) &&
    (prevChip_r != `CHIP_FAILSAFE);
  assign selwakeLive = isSelwakeCode(field_r) && !selwakeErrorFlag &&
    !woken;

  ////////////////////////////////////////////////////////////////////////////
  // field, flags and woken state
  always @* begin
    field_nxt = field_r;
    err_nxt = selwakeErrorFlag;
    armed_nxt = selwakeArmedFlag;
    cfg_nxt = selwakeConfigValid;
    sil_nxt = busSilenceFlag;
    woken_nxt = woken;
    // clear first so that any set below wins in the same cycle
    if (errClr) begin
      err_nxt = 1'b0;
    end
    if (cfgValidClr) begin
      cfg_nxt = 1'b0;
    end
    if (inNormal && fieldWr) begin
      field_nxt = fieldWrData;
      if (fieldWrData != field_r) begin
        woken_nxt = 1'b0;
      end
      if (isSelwakeCode(fieldWrData) && !isSelwakeCode(field_r)) begin
        err_nxt = !selwakeConfigValid;
      end
    end
    if (cfgValidSet && inNormal) begin
      cfg_nxt = 1'b1;
    end
    if (enterSleep) begin
      if (field_r == `FLD_RXONLY || field_r == `FLD_NORMAL) begin
        field_nxt = `FLD_WAKE;
      end else if (isSelwakeCode(field_r)) begin
        field_nxt = `FLD_SELWAKE;
      end
      woken_nxt = 1'b0;
    end
    if (enterFailsafe) begin
      field_nxt = `FLD_WAKE;
      woken_nxt = 1'b0;
    end
    if (chipMode == `CHIP_RESTART && prevChip_r != `CHIP_RESTART) begin
      cfg_nxt = 1'b0;
    end
    if (selwakeLive && busIdleTimeout) begin
      sil_nxt = 1'b1;
    end else if (wakePattern) begin
      sil_nxt = 1'b0;
    end
    if ((isSelwakeCode(field_nxt) || isSelwakeCode(field_r)) &&
        (cfgCheckFail || (errCntOverflow && selwakeLive))) begin
      err_nxt = 1'b1;
      woken_nxt = errCntOverflow ? 1'b1 : woken_nxt;
    end
    if (selwakeLive && wakeFrame) begin
      woken_nxt = 1'b1;
    end else if (!selwakeLive && (decXm == `XM_WAKE) && wakePattern &&
        (chipMode != `CHIP_NORMAL)) begin
      woken_nxt = 1'b1;
    end
    armed_nxt = isSelwakeCode(field_nxt) && !err_nxt && !woken_nxt;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      field_r <= `RST_FIELD;
      prevChip_r <= `CHIP_INIT;
      selwakeErrorFlag <= `RST_FLAG;
      selwakeArmedFlag <= `RST_FLAG;
      selwakeConfigValid <= `RST_FLAG;
      busSilenceFlag <= `RST_FLAG;
      woken <= `RST_FLAG;
      canWakeIrq <= 1'b0;
      restartReq <= 1'b0;
      fieldRd <= `RST_FIELD;
      xcvrMode <= `XM_OFF;
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
      rxOut <= 1'b1;
      txOut <= 1'b1;
    end else begin
      field_r <= field_nxt;
      prevChip_r <= chipMode;
      selwakeErrorFlag <= err_nxt;
      selwakeArmedFlag <= armed_nxt;
      selwakeConfigValid <= cfg_nxt;
      busSilenceFlag <= sil_nxt;
      woken <= woken_nxt;
      fieldRd <= field_nxt;
      // wake frame: interrupt outside sleep, restart from sleep
      canWakeIrq <= selwakeLive && wakeFrame &&
        (chipMode != `CHIP_SLEEP);
      restartReq <= selwakeLive && wakeFrame &&
        (chipMode == `CHIP_SLEEP);
      if (woken_nxt) begin
        xcvrMode <= `XM_WOKEN;
      end else if (enterFailsafe || chipMode == `CHIP_FAILSAFE) begin
        xcvrMode <= `XM_WAKE;
      end else begin
        xcvrMode <= decXm;
      end
      rxSync1_r <= busRxRaw;
      rxSync2_r <= rxSync1_r;
      // rx follows the bus only in receiving modes; wake frame does not pull
      case (xcvrMode)
        `XM_RXONLY, `XM_NORMAL, `XM_RXSW, `XM_NORMSW: rxOut <= rxSync2_r;
        default: rxOut <= 1'b1;
      endcase
      case (xcvrMode)
        `XM_NORMAL, `XM_NORMSW: txOut <= txData;
        default: txOut <= 1'b1;
      endcase
    end
  end

endmodule // can_selective_wake_mode_control
`default_nettype wire

/* File: selwake_ctl_properties.sv */
/* port checker for the transceiver mode controller
   assumes it is bound to the controller's top ports */
`timescale 1ns/10ps
`default_nettype none
`include "selwake_mode_defs.vh"
module selwake_ctl_properties (
  input wire clk,
  input wire nrst,
  input wire [2:0] chipMode,
  input wire fieldWr,
  input wire [2:0] fieldWrData,
  input wire wakeFrame,
  input wire [2:0] fieldRd,
  input wire selwakeErrorFlag,
  input wire selwakeConfigValid,
  input wire [2:0] xcvrMode,
  input wire canWakeIrq,
  input wire restartReq,
  input wire woken,
  input wire txOut
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////
sequence s_sleepIn;
  chipMode == `CHIP_NORMAL ##1 chipMode == `CHIP_SLEEP;
endsequence
a_stop_write_drop: assert property (chipMode == `CHIP_STOP && fieldWr
  |=> $stable(fieldRd)) else $error("field changed in stop");
a_normal_write: assert property (chipMode == `CHIP_NORMAL && fieldWr
  |=> fieldRd == $past(fieldWrData)) else $error("write not taken");
a_sleep_field: assert property (s_sleepIn |=> fieldRd ==
  ($past(fieldRd) > 3'h4 ? `FLD_SELWAKE : $past(fieldRd) == 3'h2
  || $past(fieldRd) == 3'h3 ? `FLD_WAKE : $past(fieldRd)))
  else $error("bad field in sleep");
a_sleep_xcvr: assert property (s_sleepIn |=> xcvrMode ==
  (fieldRd[1:0] == 2'h0 ? `XM_OFF : fieldRd[2] && !selwakeErrorFlag
  ? `XM_SELWAKE : `XM_WAKE)) else $error("bad mode in sleep");
a_wake_irq: assert property (chipMode == `CHIP_NORMAL && wakeFrame
  && xcvrMode == `XM_NORMSW |=> canWakeIrq && !restartReq)
  else $error("no wake interrupt");
a_sleep_wake: assert property (chipMode == `CHIP_SLEEP && wakeFrame
  && xcvrMode == `XM_SELWAKE |=> restartReq && woken
  && xcvrMode == `XM_WOKEN) else $error("no restart on wake");
a_restart_cfg: assert property (chipMode == `CHIP_RESTART
  |=> !selwakeConfigValid) else $error("config valid kept");
a_failsafe_wake: assert property (chipMode == `CHIP_FAILSAFE [*2]
  |-> xcvrMode == `XM_WAKE) else $error("fail-safe not wake");
a_rxsw_no_tx: assert property (xcvrMode == `XM_RXSW [*2] |-> txOut)
  else $error("driving bus in rx only");
a_err_only_sw: assert property (!fieldRd[2] && !fieldWr
  && !selwakeErrorFlag |=> !selwakeErrorFlag) else $error("error set");
endmodule // selwake_ctl_properties
bind can_selective_wake_mode_control selwake_ctl_properties chk (.clk,
  .nrst, .chipMode, .fieldWr, .fieldWrData, .wakeFrame, .fieldRd,
  .selwakeErrorFlag, .selwakeConfigValid, .xcvrMode, .canWakeIrq,
  .restartReq, .woken, .txOut);
`default_nettype wire

/* File: can_bus_model.sv */
/* wired-and CAN bus between the transceiver and one far node
   assumes recessive high; far node pulls dominant on request */
`timescale 1ns/10ps
`default_nettype none
module can_bus_model (
  input wire logic txOut,
  input wire logic farDom,
  output logic busLevel
);
  assign busLevel = txOut & ~farDom;
endmodule // can_bus_model
`default_nettype wire

/* File: can_selective_wake_mode_control_tb.sv */
/* self-checking bench for the transceiver mode controller
   assumes the defs header, the bus model and the checker */
`timescale 1ns/10ps
`default_nettype none
`include "selwake_mode_defs.vh"
module can_selective_wake_mode_control_tb;
logic clk = 0, nrst = 0, fieldWr = 0, errClr = 0, cfgSet = 0, cfgClr = 0;
logic wakeFrame = 0, busIdle = 0, txData = 0, farDom = 0;
logic [2:0] chipMode = 0, wrData = 0;
wire [2:0] fieldRd, xcvrMode;
wire errFlag, cfgValid, silence, irq, rstReq, woken, rxOut, txOut, bus;
int err_count = 0, comparisons = 0;
always #10 clk = ~clk;
can_bus_model far (.txOut(txOut), .farDom(farDom), .busLevel(bus));
can_selective_wake_mode_control uut (.clk(clk), .nrst(nrst),
  .chipMode(chipMode), .fieldWr(fieldWr), .fieldWrData(wrData),
  .errClr(errClr), .cfgValidSet(cfgSet), .cfgValidClr(cfgClr),
  .cfgCheckFail(1'b0), .errCntOverflow(1'b0), .wakeFrame(wakeFrame),
  .wakePattern(1'b0), .busIdleTimeout(busIdle), .busRxRaw(bus),
  .txData(txData), .fieldRd(fieldRd), .selwakeErrorFlag(errFlag),
  .selwakeArmedFlag(), .selwakeConfigValid(cfgValid),
  .busSilenceFlag(silence), .xcvrMode(xcvrMode), .canWakeIrq(irq),
  .restartReq(rstReq), .woken(woken), .rxOut(rxOut), .txOut(txOut));
////////////////////////////////////////////////////////////////////////////
task tick(input int n);
  repeat (n) @(posedge clk);
  #1;
endtask
task md(input logic [2:0] m);
  @(posedge clk);
  chipMode <= m;
endtask
task wr(input logic [2:0] d);
  @(posedge clk);
  fieldWr <= 1;
  wrData <= d;
  tick(1);
  fieldWr <= 0;
endtask
task pulse(input int k);
  @(posedge clk);
  case (k)
    0: errClr <= 1;
    1: cfgSet <= 1;
    2: cfgClr <= 1;
    3: wakeFrame <= 1;
    default: busIdle <= 1;
  endcase
  tick(1);
  {errClr, cfgSet, cfgClr, wakeFrame, busIdle} <= 0;
endtask
task chk(input logic [2:0] got, input logic [2:0] exp);
  comparisons++;
  if (got !== exp) begin
    err_count++;
    $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
  end
endtask
function automatic logic [2:0] xm(logic [2:0] c, logic e, logic [2:0] s);
  if (c[1:0] == 2'h0) return `XM_OFF;
  if (s == `CHIP_SLEEP) return c[2] && !e ? `XM_SELWAKE : `XM_WAKE;
  if (c == 3'h3 && s == `CHIP_STOP) return `XM_WAKE;
  if (c[2] && !e) return c - 3'h1;
  return {1'b0, c[1:0]};
endfunction
task complete_run;
  $display("comparisons %0d err_count %0d", comparisons, err_count);
  if (err_count == 0 && comparisons > 0)
    $display("Regression OK");
  else
    $display("Regression broken");
  $finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
  logic [2:0] c, s;
  logic e, tx;
  repeat (16) @(posedge clk);
  nrst <= 1;
  for (int i = 0; i < 32; i++) begin
    c = i[2:0];
    e = i[3];
    s = i[4] ? `CHIP_SLEEP : `CHIP_STOP;
    md(`CHIP_NORMAL);
    wr(3'h0);
    pulse(e ? 2 : 1);
    pulse(0);
    farDom = c[1:0] == 2'h2;
    wr(c);
    tick(5);
    tx = !(xcvrMode == `XM_NORMAL || xcvrMode == `XM_NORMSW);
    chk(xcvrMode, xm(c, e, `CHIP_NORMAL));
    chk(fieldRd, c);
    chk(errFlag, c > 3'h4 && e);
    chk(txOut, tx);
    chk(rxOut, tx & !farDom);
    md(s);
    wr(3'h2);
    tick(2);
    chk(fieldRd, s != `CHIP_SLEEP || c[2] && !c[1:0] ? c : c[2] ? 5 : c[1:0] ? 1 : 0);
    chk(xcvrMode, xm(c, e, s));
    md(`CHIP_RESTART);
  end
  md(`CHIP_NORMAL);
  pulse(1);
  pulse(0);
  wr(3'h7);
  tick(2);
  pulse(4);
  chk(silence, 1);
  pulse(3);
  chk(irq, 1);
  md(`CHIP_SLEEP);
  tick(2);
  chk(xcvrMode, `XM_SELWAKE);
  pulse(3);
  chk(rstReq, 1);
  md(`CHIP_RESTART);
  tick(2);
  chk(cfgValid, 0);
  chk(errFlag, 0);
  chk(fieldRd, `FLD_SELWAKE);
  md(`CHIP_NORMAL);
  tick(2);
  chk(xcvrMode, `XM_WOKEN);
  wr(3'h3);
  wr(3'h1);
  tick(2);
  chk(xcvrMode, `XM_WAKE);
  md(`CHIP_FAILSAFE);
  tick(3);
  chk(fieldRd, `FLD_WAKE);
  chk(xcvrMode, `XM_WAKE);
  complete_run;
end
endmodule // can_selective_wake_mode_control_tb
`default_nettype wire
